/* File: logic/io_routing_pkg.sv */
// Purpose: Shared constants and types for the camera I/O line routing block.
// Assumes: 10 MHz core clock, registers reached over a plain strobe port.
// Notes:   Offsets are byte addresses of 32-bit words.
package io_routing_pkg;

    // Core clock rate in hertz and the stretcher tick period in microseconds.
    localparam int unsigned CLOCK_HZ      = 10000000;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYCLES   = (CLOCK_HZ / 1000000) * TICK_US;
    // Largest programmable minimum pulse width, in microseconds.
    localparam int unsigned MAX_STRETCH_US = 100;
    localparam int unsigned STRETCH_W      = 7;

    // Register offsets.
    localparam logic [7:0] OFS_TRIG_SRC   = 8'h00;
    localparam logic [7:0] OFS_TARGET     = 8'h04;
    localparam logic [7:0] OFS_OUT_CFG    = 8'h08;
    localparam logic [7:0] OFS_LINE_STATE = 8'h0c;

    // Input line selection codes.
    localparam logic [1:0] IN_LINE1 = 2'h0;
    localparam logic [1:0] IN_LINE2 = 2'h1;
    localparam logic [1:0] IN_LINE3 = 2'h2;

    // Field positions inside the trigger source register.
    localparam int unsigned POS_ACQ   = 0;
    localparam int unsigned POS_FRAME = 2;
    localparam int unsigned POS_LINE  = 4;
    localparam int unsigned POS_PHA   = 6;
    localparam int unsigned POS_PHB   = 8;

    // Field positions inside the output configuration register.
    localparam int unsigned POS_WIDTH = 0;
    localparam int unsigned POS_FLIP  = 8;
    localparam int unsigned POS_SRC   = 12;

    // Output source selection.
    typedef enum logic [2:0] {
        SRC_EXPOSURE   = 3'h0,
        SRC_ACQ_WAIT   = 3'h1,
        SRC_FRAME_WAIT = 3'h2,
        SRC_LINE_WAIT  = 3'h3,
        SRC_ENCODER    = 3'h4,
        SRC_FREQ_CONV  = 3'h5,
        SRC_OFF        = 3'h6
    } out_src_t;

    // Stretcher states.
    typedef enum logic [0:0] {
        ST_IDLE    = 1'h0,
        ST_STRETCH = 1'h1
    } stretch_state_t;

endpackage

/* File: logic/tick_if.sv */
// Purpose: Carries the shared microsecond tick to the stretchers.
// Assumes: One producer, any number of consumers.
// Notes:   Tick is a one-cycle pulse.
`timescale 1ns/10ps
interface tick_if;
    logic us_tick;   // One-cycle microsecond pulse.

    modport source (output us_tick);
    modport sink   (input us_tick);
endinterface

/* File: logic/us_tick_gen.sv */
// Purpose: Divides the core clock down to a microsecond tick.
// Assumes: Core clock rate is a whole multiple of 1 MHz.
// Notes:   Tick is high for one cycle every TICK_CYCLES cycles.
`timescale 1ns/10ps
module us_tick_gen (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic srst,
    // Tick output.
    tick_if.source    tick
);
    localparam int unsigned CNT_W = $clog2(io_routing_pkg::TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(io_routing_pkg::TICK_CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;   // Cycles since the last tick.
    logic             tick_q;  // Registered tick.

    // Count cycles and pulse at the end of every microsecond.
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tick.us_tick = tick_q;
endmodule

/* File: logic/pulse_stretcher.sv */
// Purpose: Holds an active-high pulse high for at least a programmed width.
// Assumes: Width in microseconds, timed by the shared tick.
// Notes:   Width zero passes the signal through with one cycle of latency.
`timescale 1ns/10ps
module pulse_stretcher #(
    parameter int unsigned WIDTH_W = io_routing_pkg::STRETCH_W
) (
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               srst,
    // Timing.
    tick_if.sink                    tick,
    input  wire logic [WIDTH_W-1:0] min_us,
    // Signal path.
    input  wire logic               sig_in,
    output logic                    sig_out
);
    io_routing_pkg::stretch_state_t state_q;  // Stretch in progress or idle.
    logic [WIDTH_W-1:0]             left_q;   // Ticks still to hold high.
    logic                           prev_q;   // Input seen last cycle.
    logic                           out_q;    // Registered output.

    // A rising edge starts a stretch; the output stays high while the input
    // is high or the stretch has ticks left.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= io_routing_pkg::ST_IDLE;
            left_q  <= '0;
            prev_q  <= 1'b0;
            out_q   <= 1'b0;
        end else begin
            prev_q <= sig_in;
            case (state_q)
                io_routing_pkg::ST_IDLE: begin
                    // Zero width leaves pulses unchanged.
                    if (sig_in && !prev_q && min_us != '0) begin
                        state_q <= io_routing_pkg::ST_STRETCH;
                        left_q  <= min_us;
                        out_q   <= 1'b1;
                    end else begin
                        out_q <= sig_in;
                    end
                end
                io_routing_pkg::ST_STRETCH: begin
                    // Count down on ticks; the first tick may land early by
                    // up to one microsecond, so one extra tick is held.
                    if (tick.us_tick && left_q != '0) begin
                        left_q <= left_q - 1'b1;
                    end
                    if (tick.us_tick && left_q == '0) begin
                        state_q <= io_routing_pkg::ST_IDLE;
                        out_q   <= sig_in;
                    end else begin
                        out_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= io_routing_pkg::ST_IDLE;
                    out_q   <= 1'b0;
                end
            endcase
        end
    end

    assign sig_out = out_q;
endmodule

/* File: logic/camera_io_line_routing.sv */
// Purpose: Routes three input lines to camera functions and drives two
//          output lines through pulse stretchers and polarity inverters.
// Assumes: Inputs synchronous to clock; plain strobe register port.
// Notes:   Output settings apply to the line chosen by io_target_index.
`timescale 1ns/10ps
module camera_io_line_routing #(
    parameter int unsigned N_OUT = 2
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        srst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Physical input lines, after the receivers.
    input  wire logic [2:0]  in_line,
    // Internal source signals.
    input  wire logic        exposure_active,
    input  wire logic        acq_trigger_wait,
    input  wire logic        frame_trigger_wait,
    input  wire logic        line_trigger_wait,
    input  wire logic        encoder_out,
    input  wire logic        freq_conv_out,
    // Routed camera function inputs.
    output logic             acq_start_trig,
    output logic             frame_start_trig,
    output logic             line_start_trig,
    output logic             encoder_phase_a,
    output logic             encoder_phase_b,
    // Physical output lines.
    output logic [N_OUT-1:0] out_line
);
    localparam int unsigned SW = io_routing_pkg::STRETCH_W;

    // Returns the chosen input line for a two-bit selection code.
    function automatic logic pick_input(input logic [2:0] lines, input logic [1:0] sel);
        case (sel)
            io_routing_pkg::IN_LINE1: pick_input = lines[0];
            io_routing_pkg::IN_LINE2: pick_input = lines[1];
            io_routing_pkg::IN_LINE3: pick_input = lines[2];
            default:                  pick_input = 1'b0;
        endcase
    endfunction

    // Returns the internal signal for an output source code.
    function automatic logic pick_source(input io_routing_pkg::out_src_t src,
                                         input logic [5:0] sigs);
        case (src)
            io_routing_pkg::SRC_EXPOSURE:   pick_source = sigs[0];
            io_routing_pkg::SRC_ACQ_WAIT:   pick_source = sigs[1];
            io_routing_pkg::SRC_FRAME_WAIT: pick_source = sigs[2];
            io_routing_pkg::SRC_LINE_WAIT:  pick_source = sigs[3];
            io_routing_pkg::SRC_ENCODER:    pick_source = sigs[4];
            io_routing_pkg::SRC_FREQ_CONV:  pick_source = sigs[5];
            default:                        pick_source = 1'b0;
        endcase
    endfunction

    // Input source selections, one per camera function.
    logic [1:0] acq_sel_q;    // Acquisition start trigger source.
    logic [1:0] frame_sel_q;  // Frame start trigger source.
    logic [1:0] line_sel_q;   // Line start trigger source.
    logic [1:0] pha_sel_q;    // Encoder phase A source.
    logic [1:0] phb_sel_q;    // Encoder phase B source.

    // Output line selector and per-line settings.
    logic                     target_q;                 // Selected output line.
    logic [SW-1:0]            width_q [N_OUT];          // Minimum width in us.
    logic [N_OUT-1:0]         flip_q;                   // Inverter settings.
    io_routing_pkg::out_src_t src_q   [N_OUT];          // Output sources.

    logic [31:0]              rdata_q;                  // Read data register.
    logic [5:0]               src_bus;                  // Internal signals.
    logic [N_OUT-1:0]         raw_out;                  // Selected sources.
    logic [N_OUT-1:0]         stretched;                // After stretchers.
    logic [N_OUT-1:0]         line_q;                   // Driven lines.
    logic [SW-1:0]            wr_width;                 // Width being written.

    tick_if tick ();

    assign src_bus = {freq_conv_out, encoder_out, line_trigger_wait,
                      frame_trigger_wait, acq_trigger_wait, exposure_active};

    // Clamp written widths to the programmable range.
    assign wr_width = (reg_wdata[io_routing_pkg::POS_WIDTH +: SW] >
                       SW'(io_routing_pkg::MAX_STRETCH_US)) ?
                      SW'(io_routing_pkg::MAX_STRETCH_US) :
                      reg_wdata[io_routing_pkg::POS_WIDTH +: SW];

    // Input source selection register with documented defaults.
    always_ff @(posedge clock) begin
        if (srst) begin
            acq_sel_q   <= io_routing_pkg::IN_LINE1;
            line_sel_q  <= io_routing_pkg::IN_LINE1;
            pha_sel_q   <= io_routing_pkg::IN_LINE1;
            phb_sel_q   <= io_routing_pkg::IN_LINE2;
            frame_sel_q <= io_routing_pkg::IN_LINE3;
        end else if (reg_write && reg_addr == io_routing_pkg::OFS_TRIG_SRC) begin
            // Any of the three lines may be chosen for each function.
            acq_sel_q   <= reg_wdata[io_routing_pkg::POS_ACQ +: 2];
            frame_sel_q <= reg_wdata[io_routing_pkg::POS_FRAME +: 2];
            line_sel_q  <= reg_wdata[io_routing_pkg::POS_LINE +: 2];
            pha_sel_q   <= reg_wdata[io_routing_pkg::POS_PHA +: 2];
            phb_sel_q   <= reg_wdata[io_routing_pkg::POS_PHB +: 2];
        end
    end

    // Output line selector; settings written afterwards land on this line.
    always_ff @(posedge clock) begin
        if (srst) begin
            target_q <= 1'b0;
        end else if (reg_write && reg_addr == io_routing_pkg::OFS_TARGET) begin
            target_q <= reg_wdata[0];
        end
    end

    // Per-line configuration, written only for the selected line.
    generate
        for (genvar i = 0; i < N_OUT; i++) begin : g_cfg
            always_ff @(posedge clock) begin
                if (srst) begin
                    width_q[i] <= '0;
                    flip_q[i]  <= 1'b0;
                    // Line 1 shows exposure, line 2 frame trigger wait.
                    src_q[i]   <= (i == 0) ? io_routing_pkg::SRC_EXPOSURE :
                                  io_routing_pkg::SRC_FRAME_WAIT;
                end else if (reg_write && reg_addr == io_routing_pkg::OFS_OUT_CFG &&
                             32'(target_q) == i) begin
                    width_q[i] <= wr_width;
                    flip_q[i]  <= reg_wdata[io_routing_pkg::POS_FLIP];
                    src_q[i]   <= io_routing_pkg::out_src_t'(
                                  reg_wdata[io_routing_pkg::POS_SRC +: 3]);
                end
            end
        end
    endgenerate

    // Register read path; unmapped addresses read as zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                io_routing_pkg::OFS_TRIG_SRC:
                    rdata_q <= {22'h000000, phb_sel_q, pha_sel_q, line_sel_q,
                                frame_sel_q, acq_sel_q};
                io_routing_pkg::OFS_TARGET:
                    rdata_q <= {31'h00000000, target_q};
                io_routing_pkg::OFS_OUT_CFG:
                    rdata_q <= {17'h00000, src_q[target_q], 3'h0, flip_q[target_q],
                                1'b0, width_q[target_q]};
                io_routing_pkg::OFS_LINE_STATE:
                    rdata_q <= {27'h0000000, line_q, in_line};
                default:
                    rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // Registered routing of input lines to camera functions.
    always_ff @(posedge clock) begin
        if (srst) begin
            acq_start_trig   <= 1'b0;
            frame_start_trig <= 1'b0;
            line_start_trig  <= 1'b0;
            encoder_phase_a  <= 1'b0;
            encoder_phase_b  <= 1'b0;
        end else begin
            // One input may feed several functions at once.
            acq_start_trig   <= pick_input(in_line, acq_sel_q);
            frame_start_trig <= pick_input(in_line, frame_sel_q);
            line_start_trig  <= pick_input(in_line, line_sel_q);
            encoder_phase_a  <= pick_input(in_line, pha_sel_q);
            encoder_phase_b  <= pick_input(in_line, phb_sel_q);
        end
    end

    us_tick_gen u_tick (
        .clock (clock),
        .srst  (srst),
        .tick  (tick.source)
    );

    // One source mux and stretcher per output line.
    generate
        for (genvar i = 0; i < N_OUT; i++) begin : g_out
            assign raw_out[i] = pick_source(src_q[i], src_bus);

            pulse_stretcher #(
                .WIDTH_W (SW)
            ) u_stretch (
                .clock   (clock),
                .srst    (srst),
                .tick    (tick.sink),
                .min_us  (width_q[i]),
                .sig_in  (raw_out[i]),
                .sig_out (stretched[i])
            );
        end
    endgenerate

    // Inverter after the stretcher, each line on its own setting.
    always_ff @(posedge clock) begin
        if (srst) begin
            line_q <= '0;
        end else begin
            line_q <= stretched ^ flip_q;
        end
    end

    assign out_line  = line_q;
    assign reg_rdata = rdata_q;
endmodule

/* File: tb/io_sources_model.sv */
// Purpose: Model of the external trigger sources driving the input lines.
// Assumes: One clock; levels requested by the bench.
// Notes:   Levels move only just after a rising edge.
`timescale 1ns/10ps
module io_sources_model (
    // Clock.
    input  wire logic       clock,
    // Levels requested by the bench.
    input  wire logic [2:0] req_in,
    // Driven input lines.
    output logic      [2:0] in_line = 3'h0
);
    // Each level is launched after an edge and held for whole cycles, never glitched.
    always_ff @(posedge clock) begin
        in_line <= req_in;
    end
endmodule

/* File: tb/io_routing_assertions.sv */
// Purpose: Port-level checks of the I/O line routing block.
// Assumes: Sees only the top module ports.
// Notes:   Selections are internal, so routing is checked by cause.
`timescale 1ns/10ps
module io_routing_checker #(
    parameter int unsigned N_OUT = 2
) (
    input wire logic             clock,
    input wire logic             srst,
    input wire logic [7:0]       reg_addr,
    input wire logic             reg_read,
    input wire logic [31:0]      reg_rdata,
    input wire logic [2:0]       in_line,
    input wire logic             acq_start_trig,
    input wire logic             frame_start_trig,
    input wire logic             line_start_trig,
    input wire logic             encoder_phase_a,
    input wire logic             encoder_phase_b,
    input wire logic [N_OUT-1:0] out_line
);
    // All checks share the core clock and its reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_unmapped_read: assert property (reg_read && reg_addr > 8'h0c |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_state_inputs: assert property (reg_read && reg_addr == 8'h0c
        |=> reg_rdata[2:0] == $past(in_line))
        else $error("line state does not show the input lines");
    a_state_outputs: assert property (reg_read && reg_addr == 8'h0c
        |=> reg_rdata[4:3] == $past(out_line))
        else $error("line state does not show the output lines");
    a_acq_routed: assert property (acq_start_trig |-> $past(in_line) != 3'h0)
        else $error("acquisition trigger high with no input high");
    a_frame_routed: assert property (frame_start_trig |-> $past(in_line) != 3'h0)
        else $error("frame trigger high with no input high");
    a_line_routed: assert property (line_start_trig |-> $past(in_line) != 3'h0)
        else $error("line trigger high with no input high");
    a_phase_a_routed: assert property (encoder_phase_a |-> $past(in_line) != 3'h0)
        else $error("phase A high with no input high");
    a_phase_b_routed: assert property (encoder_phase_b |-> $past(in_line) != 3'h0)
        else $error("phase B high with no input high");
endmodule

bind camera_io_line_routing io_routing_checker #(.N_OUT(N_OUT)) chk (.clock, .srst,
    .reg_addr, .reg_read, .reg_rdata, .in_line, .acq_start_trig, .frame_start_trig,
    .line_start_trig, .encoder_phase_a, .encoder_phase_b, .out_line);

/* File: tb/camera_io_line_routing_test.sv */
// Purpose: Self-checking bench for the I/O line routing block.
// Assumes: 10 MHz clock, plain strobe register port.
// Notes:   Routed outputs are checked three edges after a drive.
`timescale 1ns/10ps
module camera_io_line_routing_test;
    logic        clock;      // Core clock.
    logic        srst;       // Synchronous reset.
    logic [7:0]  reg_addr;   // Register address.
    logic [31:0] reg_wdata;  // Register write data.
    logic        reg_write;  // Write strobe.
    logic        reg_read;   // Read strobe.
    logic [31:0] reg_rdata;  // Read answer.
    logic [2:0]  req_in;     // Levels asked of the source model.
    logic [2:0]  in_line;    // Input lines.
    logic [5:0]  src;        // Freq, encoder, line, frame, acq wait, exposure.
    logic [4:0]  trig;       // Acq, frame, line, phase A, phase B.
    logic [1:0]  out_line;   // Output lines.
    logic [4:0]  dflt [3];   // Default routing per driven input line.
    int          n_mismatch;
    int          n_compared;
    int          len;

    io_sources_model srcs (.clock(clock), .req_in(req_in), .in_line(in_line));
    camera_io_line_routing dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .in_line(in_line), .exposure_active(src[0]),
        .acq_trigger_wait(src[1]), .frame_trigger_wait(src[2]),
        .line_trigger_wait(src[3]), .encoder_out(src[4]), .freq_conv_out(src[5]),
        .acq_start_trig(trig[4]), .frame_start_trig(trig[3]), .line_start_trig(trig[2]),
        .encoder_phase_a(trig[1]), .encoder_phase_b(trig[0]), .out_line(out_line));

    // Free-running core clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Compares and counts one value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // One-cycle register read, answer checked in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Sets input levels and source signals, then lets three edges pass.
    task automatic drive(input logic [2:0] lines, input logic [5:0] s);
        @(posedge clock);
        req_in <= lines;
        src    <= s;
        repeat (3) @(posedge clock);
        #1;
    endtask

    // Pulses exposure for one cycle and counts the low time of inverted line 1.
    task automatic pulse_len(output int n);
        @(posedge clock);
        src[0] <= 1'b1;
        @(posedge clock);
        src[0] <= 1'b0;
        @(posedge clock);
        #1;
        n = 0;
        while (out_line[0] === 1'b0 && n < 2000) begin
            n++;
            @(posedge clock);
            #1;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short well past the expected run length.
    initial begin
        #3000000;
        n_mismatch++;
        results();
    end

    // Main sequence.
    initial begin
        srst = 1'b1; reg_addr = 8'h0; reg_wdata = 32'h0; reg_write = 1'b0;
        reg_read = 1'b0; req_in = 3'h0; src = 6'h0; n_mismatch = 0; n_compared = 0;
        dflt = '{5'b10110, 5'b00001, 5'b01000};
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        rd(8'h00, 32'h108);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h1);
        rd(8'h08, 32'h2000);
        for (int b = 0; b < 3; b++) begin
            drive(3'h1 << b, 6'h04);
            chk(trig, dflt[b]);
            chk(out_line, 2'b10);
        end
        rd(8'h0c, 32'h14);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, c * 32'h155);
            drive((c < 3) ? 3'h1 << c : 3'h7, 6'h04);
            chk(trig, (c < 3) ? 5'h1f : 5'h0);
            rd(8'h00, c * 32'h155);
        end
        wr(8'h10, 32'hffff);
        rd(8'h00, 32'h3ff);
        rd(8'h10, 32'h0);
        wr(8'h08, 32'h4100);
        wr(8'h04, 32'h0);
        for (int s = 0; s < 7; s++) begin
            wr(8'h08, s << 12);
            drive(3'h0, 6'h1 << s);
            chk(out_line, {s != 4, s < 6});
        end
        wr(8'h08, 32'h105);
        drive(3'h0, 6'h0);
        pulse_len(len);
        chk(len >= 50 && len <= 61, 1);
        wr(8'h08, 32'h100);
        pulse_len(len);
        chk(len, 1);
        wr(8'h08, 32'h17f);
        rd(8'h08, 32'h164);
        pulse_len(len);
        chk(len >= 1000 && len <= 1011, 1);
        // A reset in mid-run brings back the default selections.
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        rd(8'h00, 32'h108);
        rd(8'h08, 32'h0);
        results();
    end
endmodule
